// ---- spc_divider.sv ----
// One divider stage: emits a one-cycle pulse every limit+1 input pulses
module spc_divider #(
  parameter int CNT_W = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic freeze,
  input wire logic tickIn,
  input wire logic [CNT_W-1:0] limit,
  output logic tickOut
);
  import spc_pkg::*;

  // Whole state of the stage
  typedef struct packed {
    logic [CNT_W-1:0] cnt; // Input pulses seen in this period
    logic tick;            // Registered output pulse
  } spc_div_state_type;

  spc_div_state_type st;
  spc_div_state_type next_st;

  // Next state: clear when stopped, hold when frozen, count otherwise
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!run) begin
      next_st.cnt = '0;
    end else if (!freeze && tickIn) begin
      // Greater-or-equal so a smaller new limit cannot strand the count
      if (st.cnt >= limit) begin
        next_st.cnt = '0;
        next_st.tick = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tickOut = st.tick;
endmodule

// ---- spc_peer_model.sv ----
// Peer SPI device that stands on the serial pins of the block
module spc_peer_model (
  input wire logic peerSs,
  input wire logic peerData,
  input wire logic ssOut,
  input wire logic ssOeN,
  input wire logic mosiOut,
  input wire logic mosiOeN,
  input wire logic misoOut,
  input wire logic misoOeN,
  output logic ssIn,
  output logic mosiIn,
  output logic misoIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pin level: the block's driver wins, else the peer drives
  // Peer never fights a driven pin, so no contention level is modelled
  assign ssIn = ssOeN ? peerSs : ssOut;
  assign mosiIn = mosiOeN ? peerData : mosiOut;
  assign misoIn = misoOeN ? peerData : misoOut;
endmodule

// ---- spc_pin_rate.sv ----
// SPI pin control, mode fault and bit rate generator with Avalon-MM registers
// What this block does
// - Option bits 7,6,5,2 read as zero
// - Slave: fault enable ignored, select is input
// - Master without fault enable releases select pin
// - Master with fault enable uses select pin
// - Single-wire output enable gates the data driver
// - Separate pins: output enable bit ignored
// - Single-wire: master uses MOSI, slave MISO
// - Pin-control bit picks separate or single-wire
// - Stop-in-wait bit halts clocks during wait
// - Bit rate register accessible at any time
// - Prescaler divides by field plus one
// - Rate divider divides by two^(field+1)
// - Prescaler feeds divider, output is bit clock
// - Select output enable: fault input or output
// - Fault flag sets only on select falling
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
module spc_pin_rate (
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [spc_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Processor wait mode indication
  input wire logic waitMode,
  // Shifter side
  input wire logic txBit,
  input wire logic shifterSsOut,
  output logic rxBit,
  output logic bitRateTick,
  output logic spiClockEnable,
  output logic spiEnable,
  output logic masterSelect,
  output logic modeFault,
  output logic ssPinOwned,
  // Slave select pin
  input wire logic ssIn,
  output logic ssOut,
  output logic ssOeN,
  // Master-out data pin
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOeN,
  // Master-in data pin
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOeN
);
  import spc_pkg::*;

  // Whole state of the block
  typedef struct packed {
    logic mode_fault_enable;                // Mode fault enable
    logic bidir_output_enable;               // Single-wire output enable
    logic stopWait;              // Stop clocks in wait
    logic singleWire;            // Single-wire pin arrangement
    logic [FIELD_W-1:0] preField;  // Prescale field
    logic [FIELD_W-1:0] rateField; // Rate divide field
    logic ctlEnable;             // SPI enable
    logic ctlMaster;             // Master select
    logic ctlSsoe;               // Slave select output enable
    logic modeFault;             // Sticky mode fault flag
    logic modfArmed;             // Flag seen set by a status read
    logic ack;                   // Second cycle of a bus access
    logic [7:0] rdData;          // Captured read data
    logic ssPrev;                // Select pin one cycle ago
  } spc_state_type;

  localparam spc_state_type STATE_RESET = '{
    mode_fault_enable: OPT_RESET[OPT_MODE_FAULT_FLAG_EN_BIT],
    bidir_output_enable: OPT_RESET[OPT_BIDIR_OE_BIT],
    stopWait: OPT_RESET[OPT_STOP_WAIT_BIT],
    singleWire: OPT_RESET[OPT_SINGLE_WIRE_BIT],
    preField: RATE_RESET[RATE_PRE_LSB +: FIELD_W],
    rateField: RATE_RESET[RATE_DIV_LSB +: FIELD_W],
    ctlEnable: CTRL_RESET[CTRL_ENABLE_BIT],
    ctlMaster: CTRL_RESET[CTRL_MASTER_BIT],
    ctlSsoe: CTRL_RESET[CTRL_SLAVE_SELECT_OUTPUT_ENABLE_BIT],
    modeFault: 1'b0,
    modfArmed: 1'b0,
    ack: 1'b0,
    rdData: 8'h00,
    ssPrev: 1'b1
  };

  spc_state_type st;
  spc_state_type next_st;

  logic busReq;          // Any request present
  logic takeWrite;       // Write takes effect at this edge
  logic takeRead;        // Read completes at this edge
  logic [7:0] readValue; // Register selected by address
  logic waitStop;        // Clocks halted by wait mode
  logic modfSet;         // Mode fault event this cycle
  logic modfClear;       // Clear sequence completes this cycle
  logic preTick;         // Prescaler output pulse
  logic [DIV_CNT_W-1:0] divLimit; // Rate divider terminal count
  logic faultInput;      // Select pin is the mode fault input
  logic autoSsOut;       // Select pin is the automatic output

  // Every access takes one wait cycle, so read data come from a register
  assign busReq = read | write;
  assign waitrequest = busReq & ~st.ack;
  assign takeWrite = write & st.ack & byteenable[0];
  assign takeRead = read & st.ack;
  assign readdata = {24'h000000, st.rdData};

  // Wait mode stops clocks only when asked to
  assign waitStop = st.stopWait & waitMode;
  assign spiClockEnable = st.ctlEnable & ~waitStop;

  // Select pin role, slaves ignore the fault enable bit
  assign faultInput = st.ctlMaster & st.mode_fault_enable & ~st.ctlSsoe;
  assign autoSsOut = st.ctlMaster & st.mode_fault_enable & st.ctlSsoe;

  // Falling select pin while it serves as the fault input
  assign modfSet = st.ctlEnable & faultInput & st.ssPrev & ~ssIn;

  // Read flag while set, then write control register
  assign modfClear = takeWrite & (address == OFS_CTRL) & st.modfArmed;

  // Register read multiplexer, unimplemented bits stay zero
  always_comb begin
    readValue = 8'h00;
    case (address)
      OFS_OPTION: begin
        readValue[OPT_MODE_FAULT_FLAG_EN_BIT] = st.mode_fault_enable;
        readValue[OPT_BIDIR_OE_BIT] = st.bidir_output_enable;
        readValue[OPT_STOP_WAIT_BIT] = st.stopWait;
        readValue[OPT_SINGLE_WIRE_BIT] = st.singleWire;
      end
      OFS_RATE: begin
        readValue[RATE_PRE_LSB +: FIELD_W] = st.preField;
        readValue[RATE_DIV_LSB +: FIELD_W] = st.rateField;
      end
      OFS_CTRL: begin
        readValue[CTRL_ENABLE_BIT] = st.ctlEnable;
        readValue[CTRL_MASTER_BIT] = st.ctlMaster;
        readValue[CTRL_SLAVE_SELECT_OUTPUT_ENABLE_BIT] = st.ctlSsoe;
      end
      OFS_STATUS: begin
        readValue[STAT_MODE_FAULT_FLAG_BIT] = st.modeFault;
      end
      default: begin
        // Unmapped: reads zero, writes ignored
        readValue = 8'h00;
      end
    endcase
  end

  // Next state of registers and flags
  always_comb begin
    next_st = st;
    next_st.ack = busReq & ~st.ack;
    next_st.ssPrev = ssIn;
    // Capture read data in the waiting cycle
    if (busReq && !st.ack) begin
      next_st.rdData = readValue;
    end
    // Register writes on the completing edge
    if (takeWrite) begin
      case (address)
        OFS_OPTION: begin
          next_st.mode_fault_enable = writedata[OPT_MODE_FAULT_FLAG_EN_BIT];
          next_st.bidir_output_enable = writedata[OPT_BIDIR_OE_BIT];
          next_st.stopWait = writedata[OPT_STOP_WAIT_BIT];
          next_st.singleWire = writedata[OPT_SINGLE_WIRE_BIT];
        end
        OFS_RATE: begin
          // Accepted even mid-transfer; divider picks it up at once
          next_st.preField = writedata[RATE_PRE_LSB +: FIELD_W];
          next_st.rateField = writedata[RATE_DIV_LSB +: FIELD_W];
        end
        OFS_CTRL: begin
          next_st.ctlEnable = writedata[CTRL_ENABLE_BIT];
          next_st.ctlMaster = writedata[CTRL_MASTER_BIT];
          next_st.ctlSsoe = writedata[CTRL_SLAVE_SELECT_OUTPUT_ENABLE_BIT];
        end
        default: begin
          next_st.ctlEnable = st.ctlEnable;
        end
      endcase
    end
    // Arm the clear when software reads the flag set
    if (takeRead && address == OFS_STATUS && st.modeFault) begin
      next_st.modfArmed = 1'b1;
    end else if (modfClear) begin
      next_st.modfArmed = 1'b0;
    end
    // A new fault wins over a clear in the same cycle
    next_st.modeFault = modfSet | (st.modeFault & ~modfClear);
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Rate divider counts to 2^(field+1) - 1
  assign divLimit = DIV_CNT_W'((9'h002 << st.rateField) - 9'h001);

  // Prescaler on the bus clock
  spc_divider #(.CNT_W(PRE_CNT_W)) uPrescale (
    .clk(clk),
    .rst(rst),
    .run(st.ctlEnable),
    .freeze(waitStop),
    .tickIn(1'b1),
    .limit(st.preField),
    .tickOut(preTick)
  );

  // Rate divider fed by the prescaler
  spc_divider #(.CNT_W(DIV_CNT_W)) uRateDiv (
    .clk(clk),
    .rst(rst),
    .run(st.ctlEnable),
    .freeze(waitStop),
    .tickIn(preTick),
    .limit(divLimit),
    .tickOut(bitRateTick)
  );

  // Status outputs straight from registers
  assign spiEnable = st.ctlEnable;
  assign masterSelect = st.ctlMaster;
  assign modeFault = st.modeFault;

  // Select pin: slave input, fault input, auto output or released
  always_comb begin
    ssOut = shifterSsOut;
    ssOeN = 1'b1;
    ssPinOwned = 1'b0;
    if (st.ctlEnable) begin
      if (!st.ctlMaster) begin
        ssPinOwned = 1'b1;
      end else if (st.mode_fault_enable) begin
        ssPinOwned = 1'b1;
        ssOeN = ~autoSsOut;
      end
    end
  end

  // Data pins; the drive follows the shifter bit with no added latency
  always_comb begin
    mosiOut = txBit;
    misoOut = txBit;
    mosiOeN = 1'b1;
    misoOeN = 1'b1;
    rxBit = 1'b0;
    if (st.ctlEnable) begin
      if (st.singleWire) begin
        if (st.ctlMaster) begin
          mosiOeN = ~st.bidir_output_enable;
          rxBit = mosiIn;
        end else begin
          misoOeN = ~st.bidir_output_enable;
          rxBit = misoIn;
        end
      end else if (st.ctlMaster) begin
        mosiOeN = 1'b0;
        rxBit = misoIn;
      end else begin
        // Slave drives only while selected, to share the line
        misoOeN = ssIn;
        rxBit = mosiIn;
      end
    end
  end

  // Helper for the bit period check
  logic [GAP_W-1:0] gapCnt;
  logic gapValid;
  logic [GAP_W-1:0] expectGap;
  assign expectGap = GAP_W'(({13'h0000, st.preField} + 16'h0001)
    << ({13'h0000, st.rateField} + 16'h0001)) - 16'h0001;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gapCnt <= '0;
      gapValid <= 1'b0;
    end else begin
      gapCnt <= bitRateTick ? '0 : gapCnt + 1'b1;
      if (!st.ctlEnable || waitStop || (takeWrite && address == OFS_RATE)) begin
        gapValid <= 1'b0;
      end else if (bitRateTick) begin
        gapValid <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence sStatusRead;
    read && !waitrequest && address == OFS_STATUS && readdata[STAT_MODE_FAULT_FLAG_BIT];
  endsequence
  sequence sCtrlWrite;
    write && !waitrequest && byteenable[0] && address == OFS_CTRL;
  endsequence

  a_option_reserved_zero: assert property (
    (read && !waitrequest && address == OFS_OPTION)
      |-> readdata[7:5] == 3'h0 && readdata[2] == 1'b0)
    else $error("option reserved bits not zero");
  a_rate_unused_zero: assert property (
    (read && !waitrequest && address == OFS_RATE)
      |-> readdata[7] == 1'b0 && readdata[3] == 1'b0)
    else $error("rate unused bits not zero");
  a_slave_ss_input: assert property (
    (!masterSelect) |-> ssOeN && ssPinOwned == spiEnable)
    else $error("slave select not an input");
  a_master_ss_release: assert property (
    (masterSelect && !st.mode_fault_enable) |-> ssOeN && !ssPinOwned)
    else $error("select pin not released");
  a_ss_auto_out: assert property (
    (spiEnable && autoSsOut) |-> !ssOeN && ssOut == shifterSsOut)
    else $error("automatic select output missing");
  a_bidir_drive: assert property (
    (spiEnable && st.singleWire && masterSelect)
      |-> mosiOeN == !st.bidir_output_enable && misoOeN && rxBit == mosiIn)
    else $error("single-wire master pin wrong");
  a_bidir_ignored: assert property (
    (spiEnable && !st.singleWire && masterSelect)
      |-> !mosiOeN && misoOeN && rxBit == misoIn)
    else $error("output enable not ignored");
  a_wait_halt: assert property (
    (waitStop)[*3] |-> !bitRateTick)
    else $error("bit clock runs in wait");
  a_rate_any_time: assert property (
    (write && !waitrequest && byteenable[0] && address == OFS_RATE)
      |=> st.preField == $past(writedata[6:4])
        && st.rateField == $past(writedata[2:0]))
    else $error("rate write lost");
  a_bit_period: assert property (
    (bitRateTick && gapValid && !waitStop) |-> gapCnt == expectGap)
    else $error("bit period wrong");
  a_mode_fault_flag_set: assert property (
    (spiEnable && faultInput && $fell(ssIn)) |=> modeFault)
    else $error("mode fault not set");
  a_mode_fault_flag_cause: assert property (
    $rose(modeFault) |-> $past(spiEnable && faultInput && st.ssPrev && !ssIn))
    else $error("mode fault without cause");
  a_mode_fault_flag_clear: assert property (
    (!modfSet throughout (sStatusRead ##[1:8] sCtrlWrite)) |=> !modeFault)
    else $error("mode fault not cleared");
endmodule

// ---- spc_pin_rate_tb_top.sv ----
// Self-checking bench for the SPI pin control and bit rate block
module spc_pin_rate_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import spc_pkg::*;
  logic clk, rst, read, write, waitMode, txBit, shifterSsOut;
  logic [ADDR_W-1:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0] byteenable;
  logic waitrequest, rxBit, bitRateTick, spiClockEnable, spiEnable;
  logic masterSelect, modeFault, ssPinOwned, ssIn, ssOut, ssOeN;
  logic mosiIn, mosiOut, mosiOeN, misoIn, misoOut, misoOeN;
  logic peerSs, peerData; // Levels the peer puts on the pins
  logic m, sw, b;
  int failCount = 0, totalChecks = 0, cycles = 0, n, k;
  // Rate settings: prescale in the upper nibble, divide in the lower
  logic [7:0] rateTbl [5] = '{8'h00, 8'h70, 8'h07, 8'h23, 8'h77};

  spc_pin_rate i_spc_pin_rate (.clk(clk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .waitMode(waitMode), .txBit(txBit),
    .shifterSsOut(shifterSsOut), .rxBit(rxBit), .bitRateTick(bitRateTick),
    .spiClockEnable(spiClockEnable), .spiEnable(spiEnable),
    .masterSelect(masterSelect), .modeFault(modeFault),
    .ssPinOwned(ssPinOwned), .ssIn(ssIn), .ssOut(ssOut), .ssOeN(ssOeN),
    .mosiIn(mosiIn), .mosiOut(mosiOut), .mosiOeN(mosiOeN),
    .misoIn(misoIn), .misoOut(misoOut), .misoOeN(misoOeN));

  spc_peer_model i_spc_peer_model (.peerSs(peerSs), .peerData(peerData),
    .ssOut(ssOut), .ssOeN(ssOeN), .mosiOut(mosiOut), .mosiOeN(mosiOeN),
    .misoOut(misoOut), .misoOeN(misoOeN), .ssIn(ssIn), .mosiIn(mosiIn),
    .misoIn(misoIn));

  // Clock, 40 ns period
  always #20 clk = ~clk;

  // Hang guard: the longest rate setting needs about 6000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failCount++;
      results();
    end
  end

  // Compare one value and count it
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Hold the strobe until waitrequest is low at a rising edge
  task automatic busDone();
    // Sampled at the rising edge itself, so the request stands through it
    do @(posedge clk); while (waitrequest !== 1'b0);
  endtask

  // One Avalon write, low byte lane
  task automatic busWrite(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, d};
    write <= 1'b1;
    busDone();
    write <= 1'b0;
  endtask

  // One Avalon read; data taken at the completing edge
  task automatic busRead(input logic [ADDR_W-1:0] a,
                         output logic [31:0] d);
    @(posedge clk);
    address <= a;
    read <= 1'b1;
    busDone();
    d = readdata;
    read <= 1'b0;
  endtask

  // Cycles up to and including the next bit rate tick
  task automatic period(output int cnt);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (bitRateTick !== 1'b1 && cnt < 5000);
  endtask

  // Drop the peer select line and look at the fault flag
  task automatic ssFall(input logic exp);
    @(posedge clk);
    peerSs <= 1'b0;
    repeat (3) @(negedge clk);
    check("modeFault", modeFault, exp);
    @(posedge clk);
    peerSs <= 1'b1;
  endtask

  // Closing report, reached from the main sequence or the hang guard
  task automatic results();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0; rst = 1'b1; read = 1'b0; write = 1'b0; address = '0;
    writedata = '0; byteenable = 4'hF; waitMode = 1'b0; txBit = 1'b0;
    shifterSsOut = 1'b1; peerSs = 1'b1; peerData = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // Reset values of all four registers
    for (k = 0; k < 4; k++) begin
      busRead(ADDR_W'(k * 4), rd);
      check("reset value", rd, 32'h0);
    end
    busWrite(OFS_OPTION, 8'hFF);
    busRead(OFS_OPTION, rd);
    check("option bits", rd, 32'h1B);
    busWrite(OFS_RATE, 8'hFF);
    busRead(OFS_RATE, rd);
    check("rate bits", rd, 32'h77);
    // Unmapped place, read-only status and a masked lane change nothing
    busWrite(5'h10, 8'hFF);
    busRead(5'h10, rd);
    check("unmapped", rd, 32'h0);
    busWrite(OFS_STATUS, 8'hFF);
    busRead(OFS_STATUS, rd);
    check("status", rd, 32'h0);
    byteenable <= 4'h0;
    busWrite(OFS_OPTION, 8'h00);
    byteenable <= 4'hF;
    busRead(OFS_OPTION, rd);
    check("masked lane", rd, 32'h1B);
    // Select pin use for every master, fault enable, output enable mix
    for (k = 0; k < 8; k++) begin
      {m, sw, b} = 3'(k);
      busWrite(OFS_OPTION, {3'h0, sw, 4'h0});
      busWrite(OFS_CTRL, {5'h0, b, m, 1'b1});
      @(negedge clk);
      check("ssPinOwned", ssPinOwned, !m | sw);
      check("ssOeN", ssOeN, !(m & sw & b));
      if (!ssOeN) check("ssOut", ssOut, shifterSsOut);
      check("ctrl outputs", {spiEnable, masterSelect}, {1'b1, m});
    end
    // Fault flag: set, read, clear, and the cases that never set it
    busWrite(OFS_OPTION, 8'h10);
    busWrite(OFS_CTRL, 8'h03);
    ssFall(1'b1);
    busRead(OFS_STATUS, rd);
    check("status fault", rd, 32'h1);
    busWrite(OFS_CTRL, 8'h03);
    @(negedge clk);
    check("fault cleared", modeFault, 1'b0);
    busWrite(OFS_CTRL, 8'h07);
    ssFall(1'b0);
    busWrite(OFS_CTRL, 8'h01);
    ssFall(1'b0);
    busWrite(OFS_OPTION, 8'h00);
    busWrite(OFS_CTRL, 8'h03);
    ssFall(1'b0);
    // Data pins for master or slave, separate or single wire, oe bit
    for (k = 0; k < 8; k++) begin
      {m, sw, b} = 3'(k);
      busWrite(OFS_OPTION, {4'h0, b, 2'h0, sw});
      busWrite(OFS_CTRL, {6'h0, m, 1'b1});
      // Peer and shifter levels differ so a crossed pin shows up
      peerData <= ~b;
      txBit <= b;
      @(negedge clk);
      check("mosiOeN", mosiOeN, !(m & (!sw | b)));
      check("misoOeN", misoOeN, !(!m & sw & b));
      if (!(sw & b)) check("rxBit", rxBit, peerData);
      else check("loopback", rxBit, txBit);
    end
    // Slave with separate pins answers on the data-out pin when selected
    busWrite(OFS_OPTION, 8'h00);
    busWrite(OFS_CTRL, 8'h01);
    @(posedge clk);
    peerSs <= 1'b0;
    @(negedge clk);
    check("slave miso", misoOeN, 1'b0);
    @(posedge clk);
    peerSs <= 1'b1;
    // Bit rate period for a table of settings, with rewrites while running
    for (k = 0; k < 5; k++) begin
      busWrite(OFS_RATE, rateTbl[k]);
      busRead(OFS_RATE, rd);
      check("rate readback", rd, {24'h0, rateTbl[k]});
      period(n);
      period(n);
      period(n);
      check("period", n, (rateTbl[k][6:4] + 1) << (rateTbl[k][2:0] + 1));
    end
    // Stop in wait halts the clocks only when the bit is set
    busWrite(OFS_RATE, 8'h00);
    busWrite(OFS_OPTION, 8'h02);
    @(posedge clk);
    waitMode <= 1'b1;
    // A tick launched at the edge that raises wait mode is still legal
    @(posedge clk);
    n = 0;
    repeat (20) begin
      @(negedge clk);
      if (bitRateTick !== 1'b0) n++;
    end
    check("wait ticks", n, 0);
    check("wait clock", spiClockEnable, 1'b0);
    busWrite(OFS_OPTION, 8'h00);
    @(negedge clk);
    check("wait run", spiClockEnable, 1'b1);
    period(n);
    period(n);
    check("wait period", n, 2);
    // Reset in mid-run returns the rate register and enable to zero
    busWrite(OFS_RATE, 8'h23);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    busRead(OFS_RATE, rd);
    check("rate after reset", rd, 32'h0);
    check("enable after reset", spiEnable, 1'b0);
    results();
  end
endmodule

// ---- spc_pkg.sv ----
// Register map, field positions and reset values of the SPI pin and rate block
package spc_pkg;
  // Avalon byte address width
  localparam int ADDR_W = 5;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_OPTION = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_RATE = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h0C;
  // Option control fields
  localparam int OPT_MODE_FAULT_FLAG_EN_BIT = 4;
  localparam int OPT_BIDIR_OE_BIT = 3;
  localparam int OPT_STOP_WAIT_BIT = 1;
  localparam int OPT_SINGLE_WIRE_BIT = 0;
  // Bit rate select fields, each three bits wide
  localparam int FIELD_W = 3;
  localparam int RATE_PRE_LSB = 4;
  localparam int RATE_DIV_LSB = 0;
  // Control register fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_MASTER_BIT = 1;
  localparam int CTRL_SLAVE_SELECT_OUTPUT_ENABLE_BIT = 2;
  // Status register fields
  localparam int STAT_MODE_FAULT_FLAG_BIT = 0;
  // Reset values
  localparam logic [7:0] OPT_RESET = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Divider counter widths: prescaler 1..8, rate divider 2..256
  localparam int PRE_CNT_W = 3;
  localparam int DIV_CNT_W = 8;
  // Width of the period check counter, holds 8 * 256
  localparam int GAP_W = 16;
endpackage
